// >>> hdl/pira_pkg.sv
// Package for the indirect PHY register access block.
// Assumes a single 40 MHz clock domain and a plain strobe register port.
package pira_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  // Register offsets count 32-bit words; the port decodes byte addresses, four per word.
  localparam logic [7:0] CMD_INDEX = 8'h06;
  localparam logic [7:0] DATA_INDEX = 8'h07;
  localparam logic [7:0] CMD_ADDR = 8'h18;
  localparam logic [7:0] DATA_ADDR = 8'h1C;

  // ------------------------------------------------------------
  // Field layout and reset values
  // ------------------------------------------------------------
  localparam int PHYAD_LSB = 11;
  localparam int PHYAD_MSB = 15;
  localparam int REGIDX_LSB = 6;
  localparam int REGIDX_MSB = 10;
  localparam int WNR_BIT = 1;
  localparam int BUSY_BIT = 0;
  localparam logic [4:0] PHYAD_RESET = 5'h00;
  localparam logic [4:0] REGIDX_RESET = 5'h00;
  localparam logic [15:0] DATA_RESET = 16'h0000;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int MGMT_TURN_NS = 100;
  localparam int MGMT_TURN_CYC =
    (MGMT_TURN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Carrier from the access engine to the PHY register set.
  typedef struct packed {
    logic [4:0] target_phy_address;
    logic [4:0] reg_idx;
    logic write;
    logic [15:0] wdata;
  } pira_req_t;

endpackage

// >>> hdl/pira_regset.sv
// PHY management register set: the party the access engine talks to.
// Assumes requests are single-cycle strobes from the engine on the same clock.
`timescale 1ns/1ps
module pira_regset #(
  parameter int NUM_REGS = 32
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire pira_pkg::pira_req_t req,
  input wire logic [4:0] own_target_phy_address,
  output logic done_q,
  output logic [15:0] rdata_q
);
  import pira_pkg::*;

  // A five-bit index cannot reach more than 32 registers.
  if (NUM_REGS < 1 || NUM_REGS > 32) begin : g_bad_num_regs
    $error("NUM_REGS must lie between 1 and 32");
  end

  logic [15:0] regs_q [NUM_REGS];
  logic [$clog2(MGMT_TURN_CYC + 1):0] cnt_q;
  logic busy_q;
  pira_req_t hold_q;

  // ------------------------------------------------------------
  // Access timing
  // ------------------------------------------------------------
  // A fixed turnaround models the management access latency.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      cnt_q <= '0;
      hold_q <= '0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (req_valid && !busy_q) begin
        busy_q <= 1'b1;
        hold_q <= req;
        cnt_q <= '0;
      end else if (busy_q) begin
        cnt_q <= cnt_q + 1'b1;
        if (int'(cnt_q) == MGMT_TURN_CYC - 1) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  // An unanswered address or index reads all ones, as an idle bus would.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_q <= 16'h0000;
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_q[i] <= 16'h0000;
      end
    end else if (busy_q && int'(cnt_q) == MGMT_TURN_CYC - 1) begin
      if (hold_q.target_phy_address != own_target_phy_address || int'(hold_q.reg_idx) >= NUM_REGS) begin
        rdata_q <= 16'hFFFF;
      end else if (hold_q.write) begin
        regs_q[hold_q.reg_idx] <= hold_q.wdata;
        rdata_q <= hold_q.wdata;
      end else begin
        rdata_q <= regs_q[hold_q.reg_idx];
      end
    end
  end

endmodule

// >>> hdl/pira_top.sv
// Indirect PHY register access: command and data registers plus access engine.
// Assumes one clock, synchronous reset and a plain strobe register port.
//
// Functional notes
// - The command and data pair give software one PHY register access per transaction.
// - Command bits 10:6 pick the register index inside the addressed PHY.
// - Direction bit 1 set writes the data register to the PHY, clear reads it.
// - A read places the fetched PHY value into the data register.
// - Busy stays set for the whole access, is cleared by hardware, and resets to zero.
// - Read data is updated on the same edge that busy clears and is invalid until then.
// - The data register holds 16 bits, its upper half reads zero, and it resets to zero.
`timescale 1ns/1ps
module pira_top (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [4:0] own_target_phy_address,
  output logic [31:0] reg_rdata_q,
  output logic busy_q
);
  import pira_pkg::*;

  logic [4:0] target_phy_address_q;
  logic [4:0] reg_idx_q;
  logic wnr_q;
  logic [15:0] data_q;
  logic start_q;
  logic done;
  logic [15:0] phy_rdata;
  logic cmd_wr;
  logic data_wr;
  logic launch;
  pira_req_t req;

  function automatic logic [31:0] cmd_word(input logic [4:0] pa, input logic [4:0] ri,
                                           input logic wnr, input logic bsy);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[PHYAD_MSB:PHYAD_LSB] = pa;
    w[REGIDX_MSB:REGIDX_LSB] = ri;
    w[WNR_BIT] = wnr;
    w[BUSY_BIT] = bsy;
    return w;
  endfunction

  // ------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------
  // Writes arriving while busy are dropped so an access in flight stays coherent.
  assign cmd_wr = reg_wr && reg_addr == CMD_ADDR && !busy_q;
  assign data_wr = reg_wr && reg_addr == DATA_ADDR && !busy_q;
  assign launch = cmd_wr && reg_wdata[BUSY_BIT];

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      target_phy_address_q <= PHYAD_RESET;
      reg_idx_q <= REGIDX_RESET;
      wnr_q <= 1'b0;
    end else if (cmd_wr) begin
      target_phy_address_q <= reg_wdata[PHYAD_MSB:PHYAD_LSB];
      reg_idx_q <= reg_wdata[REGIDX_MSB:REGIDX_LSB];
      wnr_q <= reg_wdata[WNR_BIT];
    end
  end

  // ------------------------------------------------------------
  // Data register
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      data_q <= DATA_RESET;
    end else if (done && !wnr_q) begin
      data_q <= phy_rdata;
    end else if (data_wr) begin
      data_q <= reg_wdata[15:0];
    end
  end

  // ------------------------------------------------------------
  // Busy flag and launch
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      start_q <= launch;
      if (launch) begin
        busy_q <= 1'b1;
      end else if (done) begin
        busy_q <= 1'b0;
      end
    end
  end

  always_comb begin
    req.target_phy_address = target_phy_address_q;
    req.reg_idx = reg_idx_q;
    req.write = wnr_q;
    req.wdata = data_q;
  end

  pira_regset #(
    .NUM_REGS(32)
  ) u_regset (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .req_valid(start_q),
    .req(req),
    .own_target_phy_address(own_target_phy_address),
    .done_q(done),
    .rdata_q(phy_rdata)
  );

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  // Unmapped addresses read zero, as do all reserved bits.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata_q <= 32'h0000_0000;
    end else if (reg_rd && reg_addr == CMD_ADDR) begin
      reg_rdata_q <= cmd_word(target_phy_address_q, reg_idx_q, wnr_q, busy_q);
    end else if (reg_rd && reg_addr == DATA_ADDR) begin
      reg_rdata_q <= {16'h0000, data_q};
    end else begin
      reg_rdata_q <= 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_launch;
    launch;
  endsequence

  sequence s_finish;
    !busy_q [*1] ##0 $fell(busy_q);
  endsequence

  a_busy_on_launch: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_launch |=> busy_q)
    else $error("busy not set after launch");

  a_busy_holds: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(busy_q) |-> busy_q [*3])
    else $error("busy dropped too early");

  a_busy_ends: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(busy_q) |-> ##[1:20] !busy_q)
    else $error("busy never cleared");

  a_clear_cause: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_finish |-> $past(done))
    else $error("busy cleared without completion");

  a_read_data: assert property (@(posedge ref_clk) disable iff (sys_rst)
    done && !wnr_q |=> data_q == $past(phy_rdata) && !busy_q)
    else $error("read data not loaded");

  a_data_steady: assert property (@(posedge ref_clk) disable iff (sys_rst)
    busy_q && wnr_q |=> $stable(data_q))
    else $error("write data changed while busy");

  a_cmd_frozen: assert property (@(posedge ref_clk) disable iff (sys_rst)
    busy_q && !done |=> $stable(reg_idx_q) && $stable(target_phy_address_q) && $stable(wnr_q))
    else $error("command changed while busy");

  a_data_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
    reg_rd && reg_addr == DATA_ADDR |=> reg_rdata_q == {16'h0000, $past(data_q)})
    else $error("data read mismatch");

  a_cmd_resv: assert property (@(posedge ref_clk) disable iff (sys_rst)
    reg_rd && reg_addr == CMD_ADDR |=> reg_rdata_q[31:16] == 16'h0000
      && reg_rdata_q[5:2] == 4'h0 && reg_rdata_q[0] == $past(busy_q))
    else $error("command read mismatch");

  a_write_phy: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_launch |=> start_q && req.write == $past(reg_wdata[WNR_BIT])
      && req.wdata == $past(data_q))
    else $error("write request malformed");

endmodule

// >>> testbench/pira_phy_model.sv
// Reference copy of the PHY management register contents.
// Assumes the bench tells it of every write that the PHY accepts.
`timescale 1ns/1ps
module pira_phy_model (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [4:0] idx,
  input wire logic [15:0] wr_data,
  output logic [15:0] rd_data
);
  logic [15:0] mem_q [32];

  // Writes land on the indexed register only, so a stray index shows up on a later read.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 32; i++) mem_q[i] <= 16'h0000;
    end else if (wr_en) begin
      mem_q[idx] <= wr_data;
    end
  end

  assign rd_data = mem_q[idx];
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the indirect PHY register access block.
// Assumes one 40 MHz clock and the strobe register port of the design top.
`timescale 1ns/1ps
module testbench;
  import pira_pkg::*;
  logic ref_clk, sys_rst, reg_wr, reg_rd, busy_q, mdl_wr;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata_q, w;
  logic [4:0] own_target_phy_address, mdl_idx, p;
  logic [15:0] mdl_data, mdl_rdata;
  int mismatches, samples_checked, busy_run;

  pira_top dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .own_target_phy_address(own_target_phy_address), .reg_rdata_q(reg_rdata_q), .busy_q(busy_q));
  pira_phy_model mdl_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .wr_en(mdl_wr),
    .idx(mdl_idx), .wr_data(mdl_data), .rd_data(mdl_rdata));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  task automatic report_and_stop();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask

  // Strobes are left up so back-to-back writes need no second assignment in one step.
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_q;
    @(posedge ref_clk);
  endtask

  task automatic poll_idle(output logic [31:0] r);
    for (int n = 0; n < 20; n++) begin
      bus_rd(CMD_ADDR, r);
      if (r[BUSY_BIT] === 1'b0) return;
    end
    mismatches++;
    report_and_stop();
  endtask

  task automatic do_txn(input logic [4:0] phy, idx, input logic wnr,
                        input logic [15:0] d, input logic intrude);
    logic [31:0] r;
    logic [15:0] exp;
    mdl_idx <= idx;
    mdl_data <= d;
    mdl_wr <= wnr && (phy === own_target_phy_address);
    if (wnr) bus_wr(DATA_ADDR, {16'($urandom()), d});
    bus_wr(CMD_ADDR, {16'($urandom()), phy, idx, 4'($urandom()), wnr, 1'b1});
    if (intrude) begin
      bus_wr(DATA_ADDR, $urandom());
      bus_wr(CMD_ADDR, $urandom());
    end
    poll_idle(r);
    mdl_wr <= 1'b0;
    check(r, {16'h0, phy, idx, 4'h0, wnr, 1'b0});
    exp = wnr ? d : ((phy === own_target_phy_address) ? mdl_rdata : 16'hFFFF);
    bus_rd(DATA_ADDR, r);
    check(r, {16'h0, exp});
  endtask

  // Busy spans the turnaround plus one edge to start the engine and one to see it finish.
  always @(posedge ref_clk) begin
    if (busy_q === 1'b1) begin
      busy_run++;
    end else if (busy_run != 0) begin
      check(32'(busy_run), 32'(MGMT_TURN_CYC + 2));
      busy_run = 0;
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(25));
    {sys_rst, reg_wr, reg_rd, mdl_wr} = 4'h8;
    {reg_addr, reg_wdata, mdl_idx, mdl_data} = '0;
    {mismatches, samples_checked, busy_run} = '0;
    own_target_phy_address = 5'($urandom());
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    check({31'h0, busy_q}, 32'h0);
    bus_rd(CMD_ADDR, w);
    check(w, 32'h0);
    bus_rd(DATA_ADDR, w);
    check(w, 32'h0);
    bus_rd(8'h20, w);
    check(w, 32'h0);
    bus_wr(CMD_ADDR, 32'hFFFF_FFFE);
    bus_rd(CMD_ADDR, w);
    check(w, 32'h0000_FFC2);
    check({31'h0, busy_q}, 32'h0);
    bus_wr(DATA_ADDR, 32'hABCD_1234);
    bus_rd(DATA_ADDR, w);
    check(w, 32'h0000_1234);
    do_txn(own_target_phy_address, 5'h00, 1'b1, 16'hFFFF, 1'b0);
    do_txn(own_target_phy_address, 5'h00, 1'b0, 16'h0000, 1'b1);
    do_txn(own_target_phy_address, 5'h1F, 1'b1, 16'h0001, 1'b1);
    do_txn(own_target_phy_address ^ 5'h01, 5'h1F, 1'b1, 16'h5555, 1'b0);
    do_txn(own_target_phy_address, 5'h1F, 1'b0, 16'h0000, 1'b0);
    do_txn(own_target_phy_address ^ 5'h01, 5'h1F, 1'b0, 16'h0000, 1'b0);
    repeat (60) begin
      p = ($urandom() % 2) ? own_target_phy_address : 5'($urandom());
      do_txn(p, 5'($urandom()), 1'($urandom()), 16'($urandom()), 1'($urandom()));
    end
    report_and_stop();
  end
endmodule
